// ===== common/smsp_pkg.sv
package smsp_pkg;
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_SYNC_CTRL = 12'h026F;
  localparam logic [11:0] IDX_MON_CTRL = 12'h0270;
  localparam logic [11:0] IDX_PERIOD_LO = 12'h0271;
  localparam logic [11:0] IDX_PERIOD_MID = 12'h0272;
  localparam logic [11:0] IDX_PERIOD_HI = 12'h0273;
  localparam logic [11:0] IDX_STAT_CTRL = 12'h0274;
  localparam logic [11:0] IDX_STATUS0 = 12'h0275;
  localparam logic [11:0] IDX_STATUS1 = 12'h0276;
  localparam logic [11:0] IDX_STATUS2 = 12'h0277;
  localparam logic [11:0] IDX_FRAME_CNT = 12'h0278;
  localparam logic [11:0] IDX_SYSREF_CTRL = 12'h0280;

  localparam int PERIOD_W = 24;
  localparam int RESULT_W = 20;
  localparam int SAMPLE_W = 14;
  localparam int MAG_W = 13;

  localparam logic [7:0] PERIOD_LO_RST = 8'h80;
  localparam logic [7:0] PERIOD_MID_RST = 8'h00;
  localparam logic [7:0] PERIOD_HI_RST = 8'h00;
  localparam logic [2:0] RESULT_SEL_RST = 3'h1;
  localparam logic [2:0] RESULT_SEL_PEAK = 3'h1;

  // Bit positions
  localparam int SYNC_EN_BIT = 0;
  localparam int SYNC_NEXT_BIT = 1;
  localparam int PEAK_EN_BIT = 1;
  localparam int UPDATE_BIT = 4;
  localparam int SYSREF_EN_BIT = 0;

  typedef struct packed {
    logic [RESULT_W-1:0] result;
    logic [7:0] frameCount;
  } smsp_status_s;

  typedef struct packed {
    logic syncEnable;
    logic syncNext;
    logic peakEnable;
    logic [2:0] resultSel;
    logic [PERIOD_W-1:0] period;
  } smsp_cfg_s;
endpackage : smsp_pkg

// ===== hdl/smsp_peak.sv
`timescale 1ns/100ps
module smsp_peak
  import smsp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic restart,
  input wire logic [SAMPLE_W-1:0] sample,
  output logic [MAG_W-1:0] peak
);
  function automatic logic [MAG_W-1:0] magOf(input logic [SAMPLE_W-1:0] s);
    logic [SAMPLE_W-1:0] a;
    a = s[SAMPLE_W-1] ? (~s + {{(SAMPLE_W-1){1'b0}}, 1'b1}) : s;
    // Most negative code saturates
    magOf = a[SAMPLE_W-1] ? {MAG_W{1'b1}} : a[MAG_W-1:0];
  endfunction : magOf

  logic [MAG_W-1:0] mag;
  assign mag = magOf(sample);

  always_ff @(posedge clk) begin
    if (rst) begin
      peak <= '0;
    end else if (!enable) begin
      peak <= peak;
    end else if (restart) begin
      peak <= mag;
    end else if (mag > peak) begin
      peak <= mag;
    end
  end

  chk_peak_tracks: assert property (@(posedge clk) disable iff (rst)
    enable && !restart |=> peak >= $past(peak))
    else $error("peak fell inside window");
  chk_peak_frozen: assert property (@(posedge clk) disable iff (rst)
    !enable |=> $stable(peak))
    else $error("peak changed while disabled");
endmodule : smsp_peak

// ===== hdl/smsp_monitor.sv
// The APB slave port was decided locally.
`timescale 1ns/100ps
// How it works
// - Sync enable 0 blocks all realignment
// - Next mode: first edge only, clears enable
// - 24-bit period from three byte registers
// - Period resets to 128 cycles
// - Update bit copies results, self-clears
// - Continuous mode realigns every valid edge
// - Result is 20 bits over three registers
// - Frame counter counts period expiries
// - Select 001 routes peak to readback
module smsp_monitor
  import smsp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sysref,
  input wire logic [SAMPLE_W-1:0] sample,
  output logic windowEnd
);
  smsp_cfg_s cfg_q;
  smsp_status_s status_q;
  logic sysrefEnable_q;
  logic update_q;
  logic sysrefPrev_q;
  logic [PERIOD_W-1:0] count_q;
  logic [7:0] frames_q;
  logic [MAG_W-1:0] peak;

  logic access, wrAccess;
  logic [11:0] idx;
  logic mapped;
  logic sysrefEdge, realign, expire;
  logic [RESULT_W-1:0] liveResult;

  assign access = psel && penable;
  // Refused writes leave every register alone
  assign wrAccess = access && pwrite && mapped;
  assign idx = paddr[13:2];
  assign pready = 1'b1;
  assign mapped = (paddr[1:0] == 2'b00) && (idx inside {IDX_SYNC_CTRL, IDX_MON_CTRL, IDX_PERIOD_LO,
    IDX_PERIOD_MID, IDX_PERIOD_HI, IDX_STAT_CTRL, IDX_STATUS0, IDX_STATUS1, IDX_STATUS2,
    IDX_FRAME_CNT, IDX_SYSREF_CTRL}) && (paddr[15:14] == 2'b00);
  assign pslverr = access && !mapped;

  assign sysrefEdge = sysref && !sysrefPrev_q && sysrefEnable_q;
  assign realign = sysrefEdge && cfg_q.syncEnable;
  // Last cycle of the window, kept when an aligned realign lands on it; period 0 acts as 1
  assign expire = (count_q >= cfg_q.period - 24'h00_0001) || (cfg_q.period == '0);
  assign windowEnd = expire;

  // One process owns the whole config struct, so it has a single driver
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_q.period <= {PERIOD_HI_RST, PERIOD_MID_RST, PERIOD_LO_RST};
      cfg_q.syncEnable <= 1'b0;
      cfg_q.syncNext <= 1'b0;
      cfg_q.peakEnable <= 1'b0;
      cfg_q.resultSel <= RESULT_SEL_RST;
      sysrefEnable_q <= 1'b0;
    end else begin
      if (wrAccess) begin
        unique case (idx)
          IDX_SYNC_CTRL: begin
            cfg_q.syncEnable <= pwdata[SYNC_EN_BIT];
            cfg_q.syncNext <= pwdata[SYNC_NEXT_BIT];
          end
          IDX_MON_CTRL: cfg_q.peakEnable <= pwdata[PEAK_EN_BIT];
          IDX_PERIOD_LO: cfg_q.period[7:0] <= pwdata[7:0]; // Odd values stored as is
          IDX_PERIOD_MID: cfg_q.period[15:8] <= pwdata[7:0];
          IDX_PERIOD_HI: cfg_q.period[23:16] <= pwdata[7:0];
          IDX_STAT_CTRL: cfg_q.resultSel <= pwdata[2:0];
          IDX_SYSREF_CTRL: sysrefEnable_q <= pwdata[SYSREF_EN_BIT];
          default: ;
        endcase
      end
      // Later assignment: hardware clear on the consumed edge wins over a same-cycle write
      if (realign && cfg_q.syncNext) begin
        cfg_q.syncEnable <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sysrefPrev_q <= 1'b0;
    end else begin
      sysrefPrev_q <= sysref;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || realign || expire) begin
      count_q <= '0;
    end else begin
      count_q <= count_q + 24'h00_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      frames_q <= '0;
    end else if (expire) begin
      frames_q <= frames_q + 8'h01;
    end
  end

  // Restart in the first cycle of a window, so the old window's last sample is not carried over
  smsp_peak u_peak (
    .clk(clk),
    .rst(rst),
    .enable(cfg_q.peakEnable),
    .restart(count_q == '0),
    .sample(sample),
    .peak(peak)
  );

  always_comb begin
    liveResult = '0;
    if (cfg_q.resultSel == RESULT_SEL_PEAK) begin
      liveResult = {{(RESULT_W-MAG_W){1'b0}}, peak};
    end
  end

  // Update pulse, acting the next cycle; it reads back 0 because readback returns only resultSel
  always_ff @(posedge clk) begin
    if (rst) begin
      update_q <= 1'b0;
    end else begin
      update_q <= wrAccess && idx == IDX_STAT_CTRL && pwdata[UPDATE_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status_q <= '0;
    end else if (update_q) begin
      status_q.result <= liveResult;
      status_q.frameCount <= frames_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= '0;
      // Misaligned or out-of-range reads return 0
      if (mapped) begin
        unique case (idx)
          IDX_SYNC_CTRL: prdata[1:0] <= {cfg_q.syncNext, cfg_q.syncEnable};
          IDX_MON_CTRL: prdata[PEAK_EN_BIT] <= cfg_q.peakEnable;
          IDX_PERIOD_LO: prdata[7:0] <= cfg_q.period[7:0];
          IDX_PERIOD_MID: prdata[7:0] <= cfg_q.period[15:8];
          IDX_PERIOD_HI: prdata[7:0] <= cfg_q.period[23:16];
          IDX_STAT_CTRL: prdata[2:0] <= cfg_q.resultSel;
          IDX_STATUS0: prdata[7:0] <= status_q.result[7:0];
          IDX_STATUS1: prdata[7:0] <= status_q.result[15:8];
          IDX_STATUS2: prdata[3:0] <= status_q.result[19:16];
          IDX_FRAME_CNT: prdata[7:0] <= status_q.frameCount;
          IDX_SYSREF_CTRL: prdata[SYSREF_EN_BIT] <= sysrefEnable_q;
          default: ;
        endcase
      end
    end
  end

  sequence oneShotEdge;
    realign && cfg_q.syncNext;
  endsequence

  chk_sync_off_hold: assert property (@(posedge clk) disable iff (rst)
    !cfg_q.syncEnable && !expire |=> count_q == $past(count_q) + 24'h00_0001)
    else $error("window restarted while sync disabled");
  chk_oneshot_clear: assert property (@(posedge clk) disable iff (rst)
    oneShotEdge |=> !cfg_q.syncEnable)
    else $error("enable not cleared after one-shot edge");
  chk_realign_count: assert property (@(posedge clk) disable iff (rst)
    realign |=> count_q == 24'h00_0000)
    else $error("counter not restarted on realign");
  chk_window_length: assert property (@(posedge clk) disable iff (rst)
    !realign && cfg_q.period != '0 && count_q < cfg_q.period - 24'h00_0001 |=>
      count_q == $past(count_q) + 24'h00_0001)
    else $error("window counter skipped");
  chk_frame_incr: assert property (@(posedge clk) disable iff (rst)
    expire |=> frames_q == $past(frames_q) + 8'h01)
    else $error("frame count missed expiry");
  chk_update_copy: assert property (@(posedge clk) disable iff (rst)
    wrAccess && idx == IDX_STAT_CTRL && pwdata[UPDATE_BIT] |=> ##1
      status_q.frameCount == $past(frames_q))
    else $error("status not copied on update");
  chk_peak_route: assert property (@(posedge clk) disable iff (rst)
    update_q && cfg_q.resultSel == RESULT_SEL_PEAK |=>
      status_q.result == {{(RESULT_W-MAG_W){1'b0}}, $past(peak)})
    else $error("peak not routed to status");
  chk_period_reset: assert property (@(posedge clk)
    $past(rst) && !rst |-> cfg_q.period == {PERIOD_HI_RST, PERIOD_MID_RST, PERIOD_LO_RST})
    else $error("period reset value wrong");
endmodule : smsp_monitor

// ===== verification/smsp_sysref_src.sv
`timescale 1ns/100ps
module smsp_sysref_src (
  input wire logic clk,
  input wire logic fire,
  output logic sysref
);
  // Registered copy of fire, one cycle late, so a pulse lasts as long as the request; low outside pulses
  always_ff @(posedge clk) begin
    sysref <= fire;
  end
endmodule : smsp_sysref_src

// ===== verification/testbench.sv
`timescale 1ns/100ps
module testbench
  import smsp_pkg::*;
;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, fire = 0;
  logic sysref, pready, pslverr, windowEnd, er;
  logic [15:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [SAMPLE_W-1:0] sample = 0;
  logic [7:0] f0;
  int error_cnt = 0, num_checks = 0, n;
  logic [11:0] ix [7] = '{IDX_SYNC_CTRL, IDX_MON_CTRL, IDX_PERIOD_LO, IDX_PERIOD_MID, IDX_PERIOD_HI,
    IDX_STAT_CTRL, IDX_FRAME_CNT};
  logic [31:0] rv [7] = '{0, 0, 32'h0000_0080, 0, 0, 32'h0000_0001, 0};
  always #20 clk = ~clk;
  smsp_monitor i_smsp_monitor (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sysref, .sample, .windowEnd);
  smsp_sysref_src i_smsp_sysref_src (.clk, .fire, .sysref);
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(logic w, logic [11:0] idx, logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    // No wait-state limit here; the watchdog ends a hung access
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic rdchk(logic [11:0] idx, logic [31:0] exp);
    apb(1'h0, idx, 0);
    chk(rd, exp);
  endtask : rdchk
  task automatic wait_we();
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (windowEnd !== 1'h1 && n < 300);
  endtask : wait_we
  task automatic spacing(int exp);
    wait_we();
    wait_we();
    chk(n, exp);
  endtask : spacing
  // Pulse lands in the second cycle of a window (count 1), so ignored and taken edges differ
  task automatic sync_try(int exp);
    wait_we();
    @(posedge clk) fire <= 1'h1;
    @(posedge clk) fire <= 1'h0;
    @(posedge clk);
    #1;
    n = 0;
    while (windowEnd !== 1'h1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n, exp);
  endtask : sync_try
  task automatic t_reset();
    for (int i = 0; i < 7; i++) rdchk(ix[i], rv[i]);
    chk(er, 0);
    rdchk(12'h0279, 0);
    chk(er, 1);
    spacing(128);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_period();
    wait_we();
    apb(1, IDX_PERIOD_HI, 32'h0000_005A);
    rdchk(IDX_PERIOD_HI, 32'h0000_005A);
    apb(1, IDX_PERIOD_HI, 0);
    wait_we();
    // Shrink only just after a window end, so the count stays below the new limit
    apb(1, IDX_PERIOD_LO, 32'h0000_0010);
    spacing(16);
    apb(1, IDX_PERIOD_MID, 32'h0000_0001);
    apb(1, IDX_PERIOD_LO, 0);
    spacing(256);
    apb(1, IDX_PERIOD_LO, 32'h0000_0010);
    apb(1, IDX_PERIOD_MID, 0);
    spacing(16);
    $display("t_period done");
  endtask : t_period
  task automatic t_frame();
    wait_we();
    apb(1, IDX_STAT_CTRL, 32'h0000_0011);
    apb(0, IDX_FRAME_CNT, 0);
    f0 = rd[7:0];
    repeat (3) wait_we();
    apb(1, IDX_STAT_CTRL, 32'h0000_0011);
    rdchk(IDX_FRAME_CNT, {24'h00_0000, f0 + 8'h03});
    rdchk(IDX_STAT_CTRL, 32'h0000_0001);
    $display("t_frame done");
  endtask : t_frame
  task automatic t_peak();
    apb(1, IDX_MON_CTRL, 32'h0000_0002);
    wait_we();
    @(posedge clk) sample <= 14'h3F9C;
    @(posedge clk) sample <= 14'h0005;
    apb(1, IDX_STAT_CTRL, 32'h0000_0011);
    rdchk(IDX_STATUS0, 32'h0000_0064);
    rdchk(IDX_STATUS1, 0);
    rdchk(IDX_STATUS2, 0);
    repeat (2) wait_we();
    apb(1, IDX_STAT_CTRL, 32'h0000_0011);
    rdchk(IDX_STATUS0, 32'h0000_0005);
    apb(1, IDX_MON_CTRL, 0);
    sample <= 14'h00C8;
    wait_we();
    apb(1, IDX_STAT_CTRL, 32'h0000_0011);
    rdchk(IDX_STATUS0, 32'h0000_0005);
    apb(1, IDX_STAT_CTRL, 32'h0000_0010);
    rdchk(IDX_STATUS0, 0);
    $display("t_peak done");
  endtask : t_peak
  task automatic t_sync();
    apb(1, IDX_SYNC_CTRL, 32'h0000_0001);
    sync_try(13);
    apb(1, IDX_SYSREF_CTRL, 32'h0000_0001);
    apb(1, IDX_SYNC_CTRL, 0);
    sync_try(13);
    apb(1, IDX_SYNC_CTRL, 32'h0000_0001);
    repeat (2) sync_try(15);
    rdchk(IDX_SYNC_CTRL, 32'h0000_0001);
    apb(1, IDX_SYNC_CTRL, 32'h0000_0003);
    sync_try(15);
    rdchk(IDX_SYNC_CTRL, 32'h0000_0002);
    sync_try(13);
    $display("t_sync done");
  endtask : t_sync
  // Reference every second window end keeps the grid, so no window is cut short
  task automatic t_aligned();
    apb(1, IDX_SYNC_CTRL, 32'h0000_0001);
    wait_we();
    repeat (2) begin
      repeat (15) @(posedge clk);
      fire <= 1'h1;
      @(posedge clk) fire <= 1'h0;
      #1;
      chk(windowEnd, 1);
      wait_we();
      chk(n, 16);
    end
    $display("t_aligned done");
  endtask : t_aligned
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  initial begin
    #800000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    t_reset();
    t_period();
    t_frame();
    t_peak();
    t_sync();
    t_aligned();
    wrap_up();
  end
endmodule : testbench
